/* File: fault_rate_pkg.sv */
package fault_rate_pkg;
  // sizes of the fault sources around the bank
  localparam int CH_NUM   = 8;
  localparam int PAIR_NUM = 4;
  localparam int LOC1_NUM = 5;
  localparam int LOC2_NUM = 3;
  localparam int IRQ_W    = 3;

  // register offsets
  localparam logic [7:0] ADDR_GEN_TWO    = 8'h5B;
  localparam logic [7:0] ADDR_GEN_TWO_EN = 8'h5C;
  localparam logic [7:0] ADDR_SUM_ONE    = 8'h5D;
  localparam logic [7:0] ADDR_SUM_TWO    = 8'h5E;
  localparam logic [7:0] ADDR_SUM_THREE  = 8'h5F;
  localparam logic [7:0] ADDR_N_HI       = 8'h60;
  localparam logic [7:0] ADDR_N_LO       = 8'h61;
  localparam logic [7:0] ADDR_F_HI       = 8'h62;
  localparam logic [7:0] ADDR_F_LO       = 8'h63;
  localparam logic [7:0] ADDR_UPDATE     = 8'h64;
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h65;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h66;

  // reset values
  localparam logic [7:0] RST_GEN_TWO_EN = 8'h3C;
  localparam logic [3:0] RST_N_HI       = 4'h0;
  localparam logic [7:0] RST_N_LO       = 8'h80;
  localparam logic [7:0] RST_BYTE       = 8'h00;

  // field positions
  localparam int CHIP_BIT     = 5;
  localparam int INIT_BIT     = 4;
  localparam int GEN2_LOC_BIT = 4;
  localparam int GEN1_LOC_BIT = 3;
  localparam int RST_DET_BIT  = 5;
  localparam int CLK_SW_BIT   = 4;
  localparam int AREG1_BIT    = 2;
  localparam int AREG2_BIT    = 1;
  localparam int DREG_BIT     = 0;
  localparam int PSM_SEL_LSB  = 2;
  localparam int TRIP_SEL_LSB = 0;
  localparam int LOAD_SRC_BIT = 7;
  localparam int LOAD_BIT     = 0;
  localparam int IRQ_FAULT    = 0;
  localparam int IRQ_INIT     = 1;
  localparam int IRQ_LOAD     = 2;
endpackage

/* File: error_summary_and_rate_regs.sv */
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
module error_summary_and_rate_regs
(
  input  wire logic                   clk_i,           // 100 MHz clock
  input  wire logic                   arst_n_i,        // async reset, low
  input  wire logic [7:0]             addr_i,          // register address
  input  wire logic [7:0]             wdata_i,         // write data
  input  wire logic                   wr_i,            // write strobe
  input  wire logic                   rd_i,            // read strobe
  output logic      [7:0]             rdata_o,         // read data
  input  wire logic [fault_rate_pkg::CH_NUM-1:0][7:0]
                                      channel_fault_i, // per channel faults
  input  wire logic [fault_rate_pkg::PAIR_NUM-1:0][7:0]
                                      pair_sat_fault_i, // pair saturation
  input  wire logic [7:0]             gen_fault_one_i, // general group one
  input  wire logic                   reset_detect_i,  // reset was seen
  input  wire logic                   clock_switchover_fault_i, // no mclk
  input  wire logic                   analog_reg1_supply_fault_i, // areg1
  input  wire logic                   analog_reg2_supply_fault_i, // areg2
  input  wire logic                   digital_reg_supply_fault_i, // dreg
  input  wire logic                   fuse_init_done_i, // fuses loaded
  input  wire logic                   rate_load_pin_i, // external load
  output logic      [1:0]             supply_monitor_test_select_o, // psm
  output logic      [1:0]             trip_detect_test_select_o, // trip
  output logic                        rate_load_trigger_select_o, // source
  output logic      [11:0]            integer_decimation_value_o, // active
  output logic      [15:0]            fraction_decimation_value_o, // active
  output logic                        irq_o            // interrupt, high
);
  import fault_rate_pkg::*;

  typedef struct packed {
    logic [7:0]       gen_two_en;
    logic [7:0]       gen_two;
    logic [7:0]       sum_one;
    logic [7:0]       sum_two;
    logic [7:0]       sum_three;
    logic [3:0]       n_hi;
    logic [7:0]       n_lo;
    logic [7:0]       f_hi;
    logic [7:0]       f_lo;
    logic             load_src;
    logic             load_req;
    logic [11:0]      act_n;
    logic [15:0]      act_f;
    logic             init_done;
    logic             pin_q;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [7:0]       rdata;
    logic             irq;
  } state_t;

  state_t     st;
  state_t     next_st;
  logic [1:0] rst_sync;
  logic       rst_n;
  logic       any_fault;
  logic       do_load;
  logic       pin_rise;
  logic       sw_load;

  // reset release through two flops
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // load trigger selection
  assign pin_rise = rate_load_pin_i & ~st.pin_q;
  assign sw_load  = wr_i && (addr_i == ADDR_UPDATE) && wdata_i[LOAD_BIT];
  assign do_load  = st.load_src ? pin_rise : sw_load;

  // next state of the whole bank
  always_comb
  begin
    next_st = st;
    next_st.pin_q = rate_load_pin_i;
    next_st.load_req = 1'b0;
    // general fault two follows its sources
    next_st.gen_two = RST_BYTE;
    next_st.gen_two[RST_DET_BIT] = reset_detect_i
                                   & st.gen_two_en[RST_DET_BIT];
    next_st.gen_two[CLK_SW_BIT] = clock_switchover_fault_i;
    next_st.gen_two[AREG1_BIT] = analog_reg1_supply_fault_i;
    next_st.gen_two[AREG2_BIT] = analog_reg2_supply_fault_i;
    next_st.gen_two[DREG_BIT] = digital_reg_supply_fault_i;
    // fault locators
    any_fault = (|gen_fault_one_i) | (|next_st.gen_two);
    next_st.sum_one = RST_BYTE;
    next_st.sum_two = RST_BYTE;
    next_st.sum_three = RST_BYTE;
    for (int i = 0; i < CH_NUM; i++)
      any_fault = any_fault | (|channel_fault_i[i]);
    for (int i = 0; i < PAIR_NUM; i++)
    begin
      any_fault = any_fault | (|pair_sat_fault_i[i]);
      next_st.sum_three[i] = |pair_sat_fault_i[i];
    end
    for (int i = 0; i < LOC1_NUM; i++)
      next_st.sum_one[i] = |channel_fault_i[i];
    for (int i = 0; i < LOC2_NUM; i++)
      next_st.sum_two[i] = |channel_fault_i[i + LOC1_NUM];
    next_st.sum_two[GEN2_LOC_BIT] = |next_st.gen_two;
    next_st.sum_two[GEN1_LOC_BIT] = |gen_fault_one_i;
    next_st.sum_one[CHIP_BIT] = any_fault;
    next_st.sum_two[CHIP_BIT] = any_fault;
    next_st.sum_three[CHIP_BIT] = any_fault;
    // init flag stays once fuses are loaded
    next_st.init_done = st.init_done | fuse_init_done_i;
    next_st.sum_three[INIT_BIT] = next_st.init_done;
    // register writes
    if (wr_i)
    begin
      case (addr_i)
        ADDR_GEN_TWO_EN: next_st.gen_two_en = wdata_i;
        ADDR_N_HI:       next_st.n_hi = wdata_i[3:0];
        ADDR_N_LO:       next_st.n_lo = wdata_i;
        ADDR_F_HI:       next_st.f_hi = wdata_i;
        ADDR_F_LO:       next_st.f_lo = wdata_i;
        ADDR_UPDATE:
        begin
          next_st.load_src = wdata_i[LOAD_SRC_BIT];
          next_st.load_req = wdata_i[LOAD_BIT];
        end
        ADDR_IRQ_MASK:   next_st.irq_mask = wdata_i[IRQ_W-1:0];
        default:         next_st.irq_mask = st.irq_mask;
      endcase
    end
    // staged rates move to the converter only on a trigger
    if (do_load)
    begin
      next_st.act_n = {st.n_hi, st.n_lo};
      next_st.act_f = {st.f_hi, st.f_lo};
    end
    // register reads, data in the following cycle
    next_st.rdata = RST_BYTE;
    if (rd_i)
    begin
      case (addr_i)
        ADDR_GEN_TWO:    next_st.rdata = st.gen_two;
        ADDR_GEN_TWO_EN: next_st.rdata = st.gen_two_en;
        ADDR_SUM_ONE:    next_st.rdata = st.sum_one;
        ADDR_SUM_TWO:    next_st.rdata = st.sum_two;
        ADDR_SUM_THREE:  next_st.rdata = st.sum_three;
        ADDR_N_HI:       next_st.rdata = {4'h0, st.n_hi};
        ADDR_N_LO:       next_st.rdata = st.n_lo;
        ADDR_F_HI:       next_st.rdata = st.f_hi;
        ADDR_F_LO:       next_st.rdata = st.f_lo;
        ADDR_UPDATE:
        begin
          next_st.rdata[LOAD_SRC_BIT] = st.load_src;
          next_st.rdata[LOAD_BIT] = st.load_req;
        end
        ADDR_IRQ_STAT:   next_st.rdata = {5'h00, st.irq_stat};
        ADDR_IRQ_MASK:   next_st.rdata = {5'h00, st.irq_mask};
        default:         next_st.rdata = RST_BYTE;
      endcase
    end
    // sticky events, cleared by a read, a new event wins
    if (rd_i && (addr_i == ADDR_IRQ_STAT))
      next_st.irq_stat = '0;
    if (any_fault && !st.sum_one[CHIP_BIT])
      next_st.irq_stat[IRQ_FAULT] = 1'b1;
    if (next_st.init_done && !st.init_done)
      next_st.irq_stat[IRQ_INIT] = 1'b1;
    if (do_load)
      next_st.irq_stat[IRQ_LOAD] = 1'b1;
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st            <= '0;
      st.gen_two_en <= RST_GEN_TWO_EN;
      st.gen_two    <= RST_BYTE;
      st.n_hi       <= RST_N_HI;
      st.n_lo       <= RST_N_LO;
      st.act_n      <= {RST_N_HI, RST_N_LO};
    end
    else
      st <= next_st;
  end

  // outputs straight from the state flops
  assign rdata_o = st.rdata;
  assign supply_monitor_test_select_o =
    st.gen_two_en[PSM_SEL_LSB +: 2];
  assign trip_detect_test_select_o =
    st.gen_two_en[TRIP_SEL_LSB +: 2];
  assign rate_load_trigger_select_o = st.load_src;
  assign integer_decimation_value_o = st.act_n;
  assign fraction_decimation_value_o = st.act_f;
  assign irq_o = st.irq;

  // checks on the bank
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n);

  property p_chip_fault;
    ##1 1 |-> (st.sum_one[CHIP_BIT] == $past(any_fault))
      && (st.sum_two[CHIP_BIT] == st.sum_one[CHIP_BIT])
      && (st.sum_three[CHIP_BIT] == st.sum_one[CHIP_BIT]);
  endproperty
  a_chip_fault: assert property (p_chip_fault)
    else $error("chip fault bit wrong");

  property p_loc_one;
    ##1 1 |-> st.sum_one[0] == $past(|channel_fault_i[0])
      && st.sum_one[4] == $past(|channel_fault_i[4]);
  endproperty
  a_loc_one: assert property (p_loc_one)
    else $error("channel locator wrong in summary one");

  property p_loc_two;
    ##1 1 |-> st.sum_two[2] == $past(|channel_fault_i[7])
      && st.sum_two[GEN1_LOC_BIT] == $past(|gen_fault_one_i)
      && st.sum_two[GEN2_LOC_BIT] == $past(reset_detect_i
        && st.gen_two_en[RST_DET_BIT] || clock_switchover_fault_i
        || analog_reg1_supply_fault_i || analog_reg2_supply_fault_i
        || digital_reg_supply_fault_i);
  endproperty
  a_loc_two: assert property (p_loc_two)
    else $error("locator wrong in summary two");

  property p_sat_loc;
    ##1 1 |-> st.sum_three[3] == $past(|pair_sat_fault_i[3])
      && st.sum_three[0] == $past(|pair_sat_fault_i[0]);
  endproperty
  a_sat_loc: assert property (p_sat_loc)
    else $error("saturation locator wrong");

  property p_init;
    fuse_init_done_i |=> st.sum_three[INIT_BIT] [*3];
  endproperty
  a_init: assert property (p_init)
    else $error("init complete not held");

  property p_clk_sw;
    ##1 1 |-> st.gen_two[CLK_SW_BIT] == $past(clock_switchover_fault_i);
  endproperty
  a_clk_sw: assert property (p_clk_sw)
    else $error("clock switchover flag wrong");

  property p_psm_sel;
    wr_i && addr_i == ADDR_GEN_TWO_EN |=>
      supply_monitor_test_select_o == $past(wdata_i[3:2])
      && trip_detect_test_select_o == $past(wdata_i[1:0]);
  endproperty
  a_psm_sel: assert property (p_psm_sel)
    else $error("test select not taken");

  property p_n_read;
    wr_i && addr_i == ADDR_N_HI ##1 rd_i && addr_i == ADDR_N_HI
      |=> rdata_o == {4'h0, $past(wdata_i[3:0], 2)};
  endproperty
  a_n_read: assert property (p_n_read)
    else $error("integer rate high byte readback wrong");

  property p_load;
    do_load |=> integer_decimation_value_o == $past({st.n_hi, st.n_lo})
      && fraction_decimation_value_o == $past({st.f_hi, st.f_lo});
  endproperty
  a_load: assert property (p_load)
    else $error("rate transfer wrong");

  property p_hold;
    !do_load |=> $stable(integer_decimation_value_o)
      && $stable(fraction_decimation_value_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("active rate moved without trigger");

  property p_src_pin;
    st.load_src && !pin_rise |=> $stable(fraction_decimation_value_o);
  endproperty
  a_src_pin: assert property (p_src_pin)
    else $error("load ignored trigger select");

  property p_gen_two_read;
    rd_i && addr_i == ADDR_GEN_TWO |=> rdata_o == $past(st.gen_two);
  endproperty
  a_gen_two_read: assert property (p_gen_two_read)
    else $error("general fault two readback wrong");

  property p_loc_mid;
    ##1 1 |-> st.sum_one[3:1] == $past({|channel_fault_i[3],
      |channel_fault_i[2], |channel_fault_i[1]})
      && st.sum_two[1:0] == $past({|channel_fault_i[6],
      |channel_fault_i[5]});
  endproperty
  a_loc_mid: assert property (p_loc_mid)
    else $error("middle channel locators wrong");

  property p_sat_mid;
    ##1 1 |-> st.sum_three[2] == $past(|pair_sat_fault_i[2])
      && st.sum_three[1] == $past(|pair_sat_fault_i[1]);
  endproperty
  a_sat_mid: assert property (p_sat_mid)
    else $error("middle saturation locators wrong");

  property p_supply;
    ##1 1 |-> st.gen_two[AREG1_BIT] == $past(analog_reg1_supply_fault_i)
      && st.gen_two[AREG2_BIT] == $past(analog_reg2_supply_fault_i)
      && st.gen_two[DREG_BIT] == $past(digital_reg_supply_fault_i);
  endproperty
  a_supply: assert property (p_supply)
    else $error("supply fault flags wrong");

  property p_rst_det;
    ##1 1 |-> st.gen_two[RST_DET_BIT]
      == $past(reset_detect_i && st.gen_two_en[RST_DET_BIT]);
  endproperty
  a_rst_det: assert property (p_rst_det)
    else $error("reset detect flag wrong");

  property p_init_low;
    !st.init_done && !fuse_init_done_i |=> !st.sum_three[INIT_BIT];
  endproperty
  a_init_low: assert property (p_init_low)
    else $error("init complete set too early");

  property p_sw_refused;
    st.load_src && sw_load && !pin_rise |=> $stable(integer_decimation_value_o);
  endproperty
  a_sw_refused: assert property (p_sw_refused)
    else $error("software load taken with pin source");

  property p_pin_refused;
    !st.load_src && pin_rise && !sw_load |=>
      $stable(integer_decimation_value_o) && $stable(fraction_decimation_value_o);
  endproperty
  a_pin_refused: assert property (p_pin_refused)
    else $error("pin load taken with software source");

  property p_n_lo_write;
    wr_i && addr_i == ADDR_N_LO |=> st.n_lo == $past(wdata_i);
  endproperty
  a_n_lo_write: assert property (p_n_lo_write)
    else $error("integer rate low byte not staged");

  property p_f_hi_write;
    wr_i && addr_i == ADDR_F_HI |=> st.f_hi == $past(wdata_i);
  endproperty
  a_f_hi_write: assert property (p_f_hi_write)
    else $error("fraction rate high byte not staged");

  property p_load_evt;
    do_load |=> st.irq_stat[IRQ_LOAD];
  endproperty
  a_load_evt: assert property (p_load_evt)
    else $error("rate load event not flagged");

  property p_n_hi_upper;
    rd_i && addr_i == ADDR_N_HI |=> rdata_o[7:4] == 4'h0;
  endproperty
  a_n_hi_upper: assert property (p_n_hi_upper)
    else $error("integer rate high byte upper bits set");

  // main scenarios
  c_sw_load: cover property (sw_load && !st.load_src);
  c_pin_load: cover property (pin_rise && st.load_src);
  c_fault_irq: cover property (st.irq_stat[IRQ_FAULT] ##1 irq_o);
  c_init: cover property ($rose(st.sum_three[INIT_BIT]));
endmodule

/* File: error_summary_and_rate_regs_tb_top.sv */
`timescale 1ns/100ps
module error_summary_and_rate_regs_tb_top;
  import fault_rate_pkg::*;
  logic                     clk_i;
  logic                     arst_n_i;
  logic [7:0]               addr_i;
  logic [7:0]               wdata_i;
  logic                     wr_i;
  logic                     rd_i;
  logic [7:0]               rdata_o;
  logic [CH_NUM-1:0][7:0]   ch_flt;
  logic [PAIR_NUM-1:0][7:0] sat_flt;
  logic [7:0]               gen_one;
  logic [4:0]               gen_two_src; // rst det, clk sw, a1, a2, d
  logic                     init_done;
  logic                     load_pin;
  logic [1:0]               psm_sel;
  logic [1:0]               trip_sel;
  logic                     load_src;
  logic [11:0]              n_act;
  logic [15:0]              f_act;
  logic                     irq_o;
  logic [7:0]               v;
  int                       error_cnt;
  int                       checked;
  int                       en_m, init_m, src_m, n_m, f_m; // model state
  // reset value table, last entry is unmapped
  localparam logic [7:0] RA [13] = '{ADDR_GEN_TWO, ADDR_GEN_TWO_EN,
    ADDR_SUM_ONE, ADDR_SUM_TWO, ADDR_SUM_THREE, ADDR_N_HI, ADDR_N_LO,
    ADDR_F_HI, ADDR_F_LO, ADDR_UPDATE, ADDR_IRQ_STAT, ADDR_IRQ_MASK, 8'h70};
  localparam logic [7:0] RV [13] = '{8'h00, RST_GEN_TWO_EN, 8'h00, 8'h00,
    8'h00, 8'h00, RST_N_LO, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // load rounds: source written and trigger kind
  localparam int LD_SRC [6] = '{0, 1, 1, 1, 0, 0};
  localparam int LD_PIN [6] = '{0, 0, 0, 1, 0, 1};

  error_summary_and_rate_regs uut
  (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .channel_fault_i(ch_flt), .pair_sat_fault_i(sat_flt),
    .gen_fault_one_i(gen_one), .reset_detect_i(gen_two_src[4]),
    .clock_switchover_fault_i(gen_two_src[3]),
    .analog_reg1_supply_fault_i(gen_two_src[2]),
    .analog_reg2_supply_fault_i(gen_two_src[1]),
    .digital_reg_supply_fault_i(gen_two_src[0]),
    .fuse_init_done_i(init_done), .rate_load_pin_i(load_pin),
    .supply_monitor_test_select_o(psm_sel),
    .trip_detect_test_select_o(trip_sel),
    .rate_load_trigger_select_o(load_src),
    .integer_decimation_value_o(n_act),
    .fraction_decimation_value_o(f_act), .irq_o(irq_o)
  );

  // free running clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_pin(input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // one-cycle write strobe, then one idle cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // data is sampled in the only cycle it stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
    d = rdata_o;
  endtask

  // write then read the same register with no gap between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] e);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
    chk_reg(e, rdata_o);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    rd(a, v);
    chk_reg(e, v);
  endtask

  // expected summaries worked out from the driven fault sources
  task automatic check_summary();
    logic [7:0] g, s1, s2, s3;
    logic c;
    repeat (3) @(posedge clk_i);
    g = {2'h0, gen_two_src[4] & en_m[5], gen_two_src[3], 1'b0,
         gen_two_src[2:0]};
    c = (|ch_flt) | (|sat_flt) | (|gen_one) | (|g);
    s1 = {2'h0, c, 5'h00};
    s2 = {2'h0, c, |g, |gen_one, 3'h0};
    s3 = {2'h0, c, init_m[0], 4'h0};
    for (int i = 0; i < 5; i++)
      s1[i] = |ch_flt[i];
    for (int i = 0; i < 3; i++)
      s2[i] = |ch_flt[5 + i];
    for (int i = 0; i < 4; i++)
      s3[i] = |sat_flt[i];
    rd_chk(ADDR_GEN_TWO, g);
    rd_chk(ADDR_SUM_ONE, s1);
    rd_chk(ADDR_SUM_TWO, s2);
    rd_chk(ADDR_SUM_THREE, s3);
  endtask

  // stage new rates, trigger by software or pin, check load and irq
  task automatic load_round(input int src, input int pin);
    int n, f, ld;
    logic [7:0] m;
    rd(ADDR_IRQ_STAT, v);
    n = $urandom_range(4095);
    f = $urandom_range(65535);
    m = 8'($urandom_range(7));
    wr(ADDR_IRQ_MASK, m);
    wr_rd(ADDR_N_HI, {4'($urandom), 4'(n >> 8)}, 8'(n >> 8));
    wr(ADDR_N_LO, 8'(n));
    wr(ADDR_F_HI, 8'(f >> 8));
    wr(ADDR_F_LO, 8'(f));
    rd_chk(ADDR_N_HI, 8'(n >> 8));
    rd_chk(ADDR_F_HI, 8'(f >> 8));
    chk_pin(16'(n_m), 16'(n_act));
    chk_pin(16'(f_m), f_act);
    ld = (pin == src_m);
    if (pin != 0)
    begin
      load_pin <= 1'b1;
      @(posedge clk_i);
      load_pin <= 1'b0;
    end
    else
    begin
      wr(ADDR_UPDATE, {src[0], 6'h00, 1'b1});
      src_m = src;
    end
    if (ld != 0)
    begin
      n_m = n;
      f_m = f;
    end
    repeat (3) @(posedge clk_i);
    chk_pin(16'(n_m), 16'(n_act));
    chk_pin(16'(f_m), f_act);
    chk_pin(16'(src_m), 16'(load_src));
    chk_pin(16'(ld & m[2]), 16'(irq_o));
    rd_chk(ADDR_IRQ_STAT, 8'(ld << 2));
    rd_chk(ADDR_UPDATE, {src_m[0], 7'h00});
    chk_pin(16'h0000, 16'(irq_o));
  endtask

  // cuts a hang short
  initial
  begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    close_out();
  end

  // main sequence
  initial
  begin
    arst_n_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    ch_flt = '0;
    sat_flt = '0;
    gen_one = 8'h00;
    gen_two_src = 5'h00;
    init_done = 1'b0;
    load_pin = 1'b0;
    error_cnt = 0;
    checked = 0;
    en_m = RST_GEN_TWO_EN;
    init_m = 0;
    src_m = 0;
    n_m = RST_N_LO;
    f_m = 0;
    void'($urandom(32'h45C5));
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk_pin(16'h0003, 16'(psm_sel));
    chk_pin(16'h0000, 16'(trip_sel));
    chk_pin(16'(n_m), 16'(n_act));
    chk_pin(16'h0000, f_act);
    chk_pin(16'h0000, 16'(load_src));
    wr(ADDR_SUM_ONE, 8'hFF);
    wr(8'h70, 8'hFF);
    for (int i = 0; i < 13; i++)
      rd_chk(RA[i], RV[i]);
    $display("reset values done");
    for (int k = 0; k < 16; k++)
    begin
      en_m = {2'($urandom), 4'(k)};
      wr(ADDR_GEN_TWO_EN, 8'(en_m));
      chk_pin(16'(en_m[3:2]), 16'(psm_sel));
      chk_pin(16'(en_m[1:0]), 16'(trip_sel));
      rd_chk(ADDR_GEN_TWO_EN, 8'(en_m));
      for (int i = 0; i < CH_NUM; i++)
        ch_flt[i] <= ($urandom_range(2) == 0) ? 8'($urandom) : 8'h00;
      for (int i = 0; i < PAIR_NUM; i++)
        sat_flt[i] <= ($urandom_range(2) == 0) ? 8'($urandom) : 8'h00;
      gen_one <= ($urandom_range(1) == 0) ? 8'($urandom) : 8'h00;
      gen_two_src <= 5'($urandom);
      init_done <= (k == 8);
      init_m = (k >= 8);
      check_summary();
    end
    $display("summary and selects done");
    // sticky events: quiet the sources, clear, then raise one fault
    ch_flt <= '0;
    sat_flt <= '0;
    gen_one <= 8'h00;
    gen_two_src <= 5'h00;
    wr(ADDR_IRQ_MASK, 8'h01);
    rd(ADDR_IRQ_STAT, v);
    chk_reg(8'h02, v & 8'hFE);
    rd_chk(ADDR_IRQ_STAT, 8'h00);
    chk_pin(16'h0000, 16'(irq_o));
    ch_flt[3] <= 8'($urandom_range(255, 1));
    repeat (2) @(posedge clk_i);
    chk_pin(16'h0001, 16'(irq_o));
    rd_chk(ADDR_IRQ_STAT, 8'h01);
    chk_pin(16'h0000, 16'(irq_o));
    $display("fault event done");
    for (int i = 0; i < 6; i++)
      load_round(LD_SRC[i], LD_PIN[i]);
    $display("rate load done");
    close_out();
  end
endmodule
